//--- ddr2_cmd_if.sv
interface ddr2_cmd_if;
  logic        cke;
  logic        cs_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic [1:0]  ba;
  logic [12:0] addr;

  modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr);
  modport mem  (input  cke, cs_n, ras_n, cas_n, we_n, ba, addr);
endinterface : ddr2_cmd_if

//--- ddr2_init_and_mode_program_tb.sv
`include "ddr2_init_defs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end

module ddr2_init_and_mode_program_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0, rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, snap = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] rdat;
  logic        ack, inter, tmode, slow_exit, dlle, dlll, half, strn, hot, sref;
  logic [3:0]  beats, wr_rec, regs_w;
  logic [2:0]  cl, add_lat, cal, par;
  logic [1:0]  term;
  logic [12:0] mr, e1, e2;
  logic [63:0] exp_q[$];
  int          errors = 0, n_tests = 0;
  wire  [63:0] dev = {29'h0, beats, inter, cl, tmode, wr_rec, slow_exit, dlle, dlll, half, add_lat,
                      term, cal, strn, par, hot, sref, regs_w};
  ddr2_cmd_if link ();
  wire         cal_def = ({link.cs_n, link.ras_n, link.cas_n, link.we_n} == `CMD_MRS) &&
                         link.ba == `BA_EXT1 && link.addr[9:7] == 3'h7;

  always #5 clk_i = ~clk_i;

  ddr2_init_ctrl #(.INIT_WAIT_CYC(50)) ddr2_init_ctrl_i (.clk_i, .rst_i, .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .mem(link.ctrl));
  ddr2_mem_end ddr2_mem_end_i (.clk_i, .rst_i, .bus(link.mem), .burst_beats_o(beats),
    .burst_interleaved_o(inter), .cas_latency_o(cl), .test_mode_o(tmode),
    .write_recovery_o(wr_rec), .powerdown_exit_slow_o(slow_exit), .dll_enabled_o(dlle),
    .dll_locked_o(dlll), .half_strength_o(half), .additive_latency_o(add_lat),
    .termination_sel_o(term), .driver_calibration_o(cal), .strobe_n_disabled_o(strn),
    .partial_array_refresh_o(par), .high_temp_refresh_o(hot), .self_refresh_o(sref),
    .regs_written_o(regs_w));
  ddr2_init_sva ddr2_init_sva_i (.clk_i, .rst_i, .cke(link.cke), .cs_n(link.cs_n),
    .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .ba(link.ba), .addr(link.addr));

  ////////////////////////////////////////////////////////////////////////////////
  // valid only for burst codes 4 and 8, latency codes 3 to 6 and a nonzero recovery code
  function automatic logic [63:0] exp_dev(input logic [12:0] m, x, y);
    logic [3:0] b;
    b = (m[2:0] == `BURST_CODE_4) ? `BURST_BEATS_4 : `BURST_BEATS_8;
    return {29'h0, b, m[3], m[6:4], 1'b0, {1'b0, m[11:9]} + 4'h1, m[12], 2'b11, x[1],
            x[5:3], x[6], x[2], 3'h0, x[10], y[2:0], y[7], 1'b0, 4'hf};
  endfunction : exp_dev

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= 4'h3;
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back({32'h0, e});
    wb(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic look(input logic [63:0] e);
    exp_q.push_back(e);
    @(posedge clk_i);
    snap <= 1'b1;
    @(posedge clk_i);
    snap <= 1'b0;
  endtask : look

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    if ((ack === 1'b1 && !we) || snap) begin
      `CHK(snap ? "decoded" : "read", exp_q[0], snap ? dev : {32'h0, rdat})
      void'(exp_q.pop_front());
    end
  end

  initial begin
    repeat (6000) @(posedge clk_i);
    errors++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(1976));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`OFS_MR_CFG, 32'h0000_0232);
    rd(`OFS_EXT1_CFG, 32'h0000_0000);
    rd(`OFS_EXT2_CFG, 32'h0000_0000);
    rd(`OFS_STATUS, 32'h0000_0000);
    wb(1'b1, 8'h44, 32'hffff_ffff);
    rd(8'h44, 32'h0000_0000);
    // zeroed images: a clear loop-disable bit leaves only the loop-enabled output high
    look(64'h0000_0000_0010_0000);
    // every pass after the first restarts from ready, with every burst length and order pairing covered
    for (int k = 0; k < 4; k++) begin
      mr = 13'($urandom);
      mr[2:0] = k[0] ? `BURST_CODE_8 : `BURST_CODE_4;
      mr[3] = k[1];
      mr[6:4] = 3'(`CL_MIN_CODE + $urandom_range(3));
      mr[11:9] = 3'(1 + $urandom_range(6));
      e1 = 13'($urandom);
      e2 = 13'($urandom);
      wb(1'b1, `OFS_MR_CFG, {19'h0, mr});
      wb(1'b1, `OFS_EXT1_CFG, {19'h0, e1});
      wb(1'b1, `OFS_EXT2_CFG, {19'h0, e2});
      rd(`OFS_MR_CFG, {19'h0, mr});
      wb(1'b1, `OFS_CTRL, 32'h0000_0001);
      rd(`OFS_STATUS, 32'h0000_0011);
      for (int n = 0; n < 3000; n++) begin
        @(posedge clk_i);
        if (cal_def) break;
      end
      repeat (8) @(posedge clk_i);
      rd(`OFS_STATUS, 32'h0000_00c2);
      look(exp_dev(mr, e1, e2));
    end
    tally_and_finish();
  end
endmodule : ddr2_init_and_mode_program_tb

//--- ddr2_init_ctrl.sv
// The Wishbone slave port and the register addresses were decided locally.
`include "ddr2_init_defs.svh"

// How it works
// - wait 200us, then NOP and raise clock enable
// - 400ns of NOPs, then precharge all
// - program second, then third extended register
// - first extended register, loop enabled
// - main register with loop reset set
// - precharge all, then two or more refreshes
// - main register again, loop reset clear
// - calibration step 200 clocks after loop reset
// - driver default, then calibration exit writes
// - device takes register write on all-low command
// - banks precharged, clock enable high, spacing kept
// - burst length codes four and eight beats
// - burst order sequential or interleaved
// - read latency field programmed by software
// - test and loop reset bits zero normally
// - bank bits pick the target register
// - power-down exit fast or slow select
// - write recovery field taken from software
// - first extended register field layout
// - loop off in self-refresh, on after
// - 200 clocks after loop reset before reads
// - second extended register reserved bits zero

module ddr2_init_ctrl #(
  parameter int unsigned INIT_WAIT_CYC = `INIT_WAIT_US * `CLK_MHZ,
  parameter int unsigned CKE_WAIT_CYC  = (`CKE_WAIT_NS * `CLK_MHZ + 999) / 1000,
  parameter int unsigned MRD_CYC       = `REG_SET_GAP_CLKS,
  parameter int unsigned RP_CYC        = `PRE_GAP_CLKS,
  parameter int unsigned RFC_CYC       = `REF_GAP_CLKS,
  parameter int unsigned REF_COUNT     = `REF_CMDS,
  parameter int unsigned DLL_LOCK_CYC  = `DLL_LOCK_CLKS
) (
  // system
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // command bus
  ddr2_cmd_if.ctrl         mem
);

  localparam int WAIT_W = $clog2(INIT_WAIT_CYC + 1);

  // byte-lane merge for a 13-bit register image
  function automatic logic [12:0] merge(input logic [12:0] old, input logic [31:0] dat,
                                        input logic [3:0] sel);
    merge = {sel[1] ? dat[12:8] : old[12:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction : merge

  ddr2_init_pkg::init_state_t state_r;
  ddr2_init_pkg::init_state_t state_nxt;
  logic [WAIT_W-1:0] wait_r;
  logic [WAIT_W-1:0] wait_nxt;
  logic [7:0]        dll_r;
  logic [7:0]        dll_nxt;
  logic [3:0]        ref_r;
  logic [3:0]        ref_nxt;
  logic [3:0]        cmd_r;
  logic [3:0]        cmd_nxt;
  logic [1:0]        ba_r;
  logic [1:0]        ba_nxt;
  logic [12:0]       addr_r;
  logic [12:0]       addr_nxt;
  logic              cke_r;
  logic              cke_nxt;
  logic [12:0]       mr_cfg_r;
  logic [12:0]       ext1_cfg_r;
  logic [12:0]       ext2_cfg_r;

  ////////////////////////////////////////////////////////////////////////
  // register access

  wire        wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wb_wr    = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;  // lands at the ack edge
  wire        sel_ctrl = (wb_adr_i == `OFS_CTRL);
  wire        sel_stat = (wb_adr_i == `OFS_STATUS);
  wire        sel_mr   = (wb_adr_i == `OFS_MR_CFG);
  wire        sel_ext1 = (wb_adr_i == `OFS_EXT1_CFG);
  wire        sel_ext2 = (wb_adr_i == `OFS_EXT2_CFG);
  wire        idle_now = (state_r == ddr2_init_pkg::IDLE) | (state_r == ddr2_init_pkg::READY);
  wire        busy     = ~idle_now;
  wire        ready    = (state_r == ddr2_init_pkg::READY);
  // start is ignored while a sequence runs
  wire        start    = wb_wr & sel_ctrl & wb_sel_i[0] & wb_dat_i[`CTRL_START_B] & idle_now;
  wire [31:0] status   = {24'h00_0000, 4'(state_r), 2'h0, ready, busy};
  wire [31:0] rd_data  = sel_stat ? status :
                         sel_mr   ? {19'h0_0000, mr_cfg_r} :
                         sel_ext1 ? {19'h0_0000, ext1_cfg_r} :
                         sel_ext2 ? {19'h0_0000, ext2_cfg_r} : 32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_data : wb_dat_o;
    end
  end

  // images may change mid-sequence; each write takes the value current then
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mr_cfg_r   <= `MR_CFG_RST;
      ext1_cfg_r <= `EXT1_CFG_RST;
      ext2_cfg_r <= `EXT2_CFG_RST;
    end else if (wb_wr) begin
      if (sel_mr) mr_cfg_r <= merge(mr_cfg_r, wb_dat_i, wb_sel_i);
      if (sel_ext1) ext1_cfg_r <= merge(ext1_cfg_r, wb_dat_i, wb_sel_i);
      if (sel_ext2) ext2_cfg_r <= merge(ext2_cfg_r, wb_dat_i, wb_sel_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register images sent to the memory

  wire [12:0] mr_oper   = mr_cfg_r & `MR_OPER_MASK;
  wire [12:0] mr_reset  = mr_oper | `MR_DLL_RESET;
  wire [12:0] ext1_oper = ext1_cfg_r & `EXT1_OPER_MASK;
  wire [12:0] ext1_def  = ext1_oper | `EXT1_CAL_DEFAULT;
  wire [12:0] ext2_oper = ext2_cfg_r & `EXT2_OPER_MASK;
  wire        gap_done  = (wait_r == {WAIT_W{1'b0}});
  wire        dll_done  = (dll_r == 8'h00);

  ////////////////////////////////////////////////////////////////////////
  // init sequencer

  always_comb begin
    state_nxt = state_r;
    wait_nxt  = gap_done ? wait_r : wait_r - WAIT_W'(1);
    dll_nxt   = dll_done ? dll_r : dll_r - 8'h01;
    ref_nxt   = ref_r;
    cmd_nxt   = `CMD_NOP;
    ba_nxt    = `BA_MAIN;
    addr_nxt  = `ADDR_ZERO;
    cke_nxt   = cke_r;
    unique case (state_r)
      ddr2_init_pkg::IDLE, ddr2_init_pkg::READY: begin
        if (start) begin
          state_nxt = ddr2_init_pkg::PWR_WAIT;
          wait_nxt  = WAIT_W'(INIT_WAIT_CYC - 1);
          cke_nxt   = 1'b0;
        end
      end
      ddr2_init_pkg::PWR_WAIT: begin
        if (gap_done) begin
          cke_nxt   = 1'b1;
          wait_nxt  = WAIT_W'(CKE_WAIT_CYC - 1);
          state_nxt = ddr2_init_pkg::PRE_A;
        end
      end
      ddr2_init_pkg::PRE_A: begin
        if (gap_done) begin
          cmd_nxt   = `CMD_PRE;
          addr_nxt  = `PRE_ALL_ADDR;
          wait_nxt  = WAIT_W'(RP_CYC - 1);
          state_nxt = ddr2_init_pkg::LD_EXT2;
        end
      end
      ddr2_init_pkg::LD_EXT2: begin
        if (gap_done) begin
          cmd_nxt   = `CMD_MRS;
          ba_nxt    = `BA_EXT2;
          addr_nxt  = ext2_oper;
          wait_nxt  = WAIT_W'(MRD_CYC - 1);
          state_nxt = ddr2_init_pkg::LD_EXT3;
        end
      end
      ddr2_init_pkg::LD_EXT3: begin
        if (gap_done) begin
          cmd_nxt   = `CMD_MRS;
          ba_nxt    = `BA_EXT3;
          wait_nxt  = WAIT_W'(MRD_CYC - 1);
          state_nxt = ddr2_init_pkg::LD_EXT1;
        end
      end
      ddr2_init_pkg::LD_EXT1: begin
        if (gap_done) begin
          cmd_nxt   = `CMD_MRS;
          ba_nxt    = `BA_EXT1;
          addr_nxt  = ext1_oper;
          wait_nxt  = WAIT_W'(MRD_CYC - 1);
          state_nxt = ddr2_init_pkg::LD_MR_RST;
        end
      end
      ddr2_init_pkg::LD_MR_RST: begin
        if (gap_done) begin
          cmd_nxt   = `CMD_MRS;
          addr_nxt  = mr_reset;
          wait_nxt  = WAIT_W'(MRD_CYC - 1);
          dll_nxt   = 8'(DLL_LOCK_CYC - 1);
          state_nxt = ddr2_init_pkg::PRE_B;
        end
      end
      ddr2_init_pkg::PRE_B: begin
        if (gap_done) begin
          cmd_nxt   = `CMD_PRE;
          addr_nxt  = `PRE_ALL_ADDR;
          wait_nxt  = WAIT_W'(RP_CYC - 1);
          ref_nxt   = 4'h0;
          state_nxt = ddr2_init_pkg::AUTO_REF;
        end
      end
      ddr2_init_pkg::AUTO_REF: begin
        if (gap_done) begin
          cmd_nxt  = `CMD_REF;
          wait_nxt = WAIT_W'(RFC_CYC - 1);
          ref_nxt  = ref_r + 4'h1;
          if (ref_r == 4'(REF_COUNT - 1)) state_nxt = ddr2_init_pkg::LD_MR_OP;
        end
      end
      ddr2_init_pkg::LD_MR_OP: begin
        if (gap_done) begin
          cmd_nxt   = `CMD_MRS;
          addr_nxt  = mr_oper;
          wait_nxt  = WAIT_W'(MRD_CYC - 1);
          state_nxt = ddr2_init_pkg::LD_CAL_DEF;
        end
      end
      ddr2_init_pkg::LD_CAL_DEF: begin
        if (gap_done && dll_done) begin
          cmd_nxt   = `CMD_MRS;
          ba_nxt    = `BA_EXT1;
          addr_nxt  = ext1_def;
          wait_nxt  = WAIT_W'(MRD_CYC - 1);
          state_nxt = ddr2_init_pkg::LD_CAL_EXIT;
        end
      end
      ddr2_init_pkg::LD_CAL_EXIT: begin
        if (gap_done) begin
          cmd_nxt   = `CMD_MRS;
          ba_nxt    = `BA_EXT1;
          addr_nxt  = ext1_oper;
          wait_nxt  = WAIT_W'(MRD_CYC - 1);
          state_nxt = ddr2_init_pkg::READY;
        end
      end
      default: begin
        state_nxt = ddr2_init_pkg::IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ddr2_init_pkg::IDLE;
      wait_r  <= {WAIT_W{1'b0}};
      dll_r   <= 8'h00;
      ref_r   <= 4'h0;
      cmd_r   <= `CMD_NOP;
      ba_r    <= `BA_MAIN;
      addr_r  <= `ADDR_ZERO;
      cke_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      wait_r  <= wait_nxt;
      dll_r   <= dll_nxt;
      ref_r   <= ref_nxt;
      cmd_r   <= cmd_nxt;
      ba_r    <= ba_nxt;
      addr_r  <= addr_nxt;
      cke_r   <= cke_nxt;
    end
  end

  assign mem.cke   = cke_r;
  assign mem.cs_n  = cmd_r[3];
  assign mem.ras_n = cmd_r[2];
  assign mem.cas_n = cmd_r[1];
  assign mem.we_n  = cmd_r[0];
  assign mem.ba    = ba_r;
  assign mem.addr  = addr_r;

endmodule : ddr2_init_ctrl

//--- ddr2_init_defs.svh
`ifndef DDR2_INIT_DEFS_SVH
`define DDR2_INIT_DEFS_SVH

// clock and timing figures
`define CLK_MHZ            100
`define INIT_WAIT_US       200
`define CKE_WAIT_NS        400
`define DLL_LOCK_CLKS      200
`define REG_SET_GAP_CLKS   2
`define PRE_GAP_CLKS       4
`define REF_GAP_CLKS       32
`define REF_CMDS           2

// command codes {cs_n, ras_n, cas_n, we_n}
`define CMD_NOP            4'h7
`define CMD_PRE            4'h2
`define CMD_REF            4'h1
`define CMD_MRS            4'h0

// bank codes of the register-set targets
`define BA_MAIN            2'h0
`define BA_EXT1            2'h1
`define BA_EXT2            2'h2
`define BA_EXT3            2'h3

// address images
`define ADDR_ZERO          13'h0000
`define PRE_ALL_ADDR       13'h0400
`define MR_OPER_MASK       13'h1e7f
`define MR_DLL_RESET       13'h0100
`define EXT1_OPER_MASK     13'h1c7e
`define EXT1_CAL_DEFAULT   13'h0380
`define EXT2_OPER_MASK     13'h0087

// main register fields
`define MR_BURST_F         2:0
`define MR_ORDER_B         3
`define MR_CL_F            6:4
`define MR_TEST_B          7
`define MR_DLLRST_B        8
`define MR_WR_F            11:9
`define MR_PWRDN_B         12

// first extended register fields
`define EX1_DLL_DIS_B      0
`define EX1_HALF_B         1
`define EX1_RTT_LO_B       2
`define EX1_ADDLAT_F       5:3
`define EX1_RTT_HI_B       6
`define EX1_CAL_F          9:7
`define EX1_STROBE_N_B     10

// second extended register fields
`define EX2_PAR_F          2:0
`define EX2_HOT_B          7

// burst length and latency codes
`define BURST_CODE_4       3'h2
`define BURST_CODE_8       3'h3
`define BURST_BEATS_4      4'h4
`define BURST_BEATS_8      4'h8
`define CL_MIN_CODE        3'h3
`define CL_MAX_CODE        3'h6

// register file of the controller, byte offsets
`define OFS_CTRL           8'h00
`define OFS_STATUS         8'h04
`define OFS_MR_CFG         8'h08
`define OFS_EXT1_CFG       8'h0c
`define OFS_EXT2_CFG       8'h10
`define CTRL_START_B       0

// reset values of the operating images: 4 beats, CL 3, WR 2
`define MR_CFG_RST         13'h0232
`define EXT1_CFG_RST       13'h0000
`define EXT2_CFG_RST       13'h0000

`endif

//--- ddr2_init_pkg.sv
package ddr2_init_pkg;

  typedef enum logic [3:0] {
    IDLE        = 4'b0000,
    PWR_WAIT    = 4'b0001,
    PRE_A       = 4'b0010,
    LD_EXT2     = 4'b0011,
    LD_EXT3     = 4'b0100,
    LD_EXT1     = 4'b0101,
    LD_MR_RST   = 4'b0110,
    PRE_B       = 4'b0111,
    AUTO_REF    = 4'b1000,
    LD_MR_OP    = 4'b1001,
    LD_CAL_DEF  = 4'b1010,
    LD_CAL_EXIT = 4'b1011,
    READY       = 4'b1100
  } init_state_t;

endpackage : ddr2_init_pkg

//--- ddr2_init_sva.sv
`include "ddr2_init_defs.svh"

module ddr2_init_sva #(
  parameter int unsigned DLL_LOCK_CYC = `DLL_LOCK_CLKS
) (
  // system
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // command bus
  input  wire logic        cke,
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [1:0]  ba,
  input  wire logic [12:0] addr
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  wire logic [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
  wire logic       mrs = (cmd == `CMD_MRS);
  logic      [8:0] since_rst_r;

  ////////////////////////////////////////////////////////////////////////////////
  // saturates so a long pause never wraps back under the lock span
  always_ff @(posedge clk_i) begin
    if (rst_i || (mrs && ba == `BA_MAIN && addr[8])) since_rst_r <= 9'h000;
    else if (since_rst_r != 9'h1ff) since_rst_r <= since_rst_r + 9'h001;
  end

  ////////////////////////////////////////////////////////////////////////////////
  chk_cke_wait: assert property ($rose(cke) |-> (cmd == `CMD_NOP)[*8] ##33
    (cmd == `CMD_PRE && addr[10])) else $error("precharge not 40 clocks after clock enable");
  chk_pre_ext2: assert property (mrs && ba == `BA_EXT2 |-> $past(cmd == `CMD_PRE, 4))
    else $error("second extended write not after precharge");
  chk_ext_order: assert property (mrs && ba == `BA_EXT2 |-> ##2 (mrs && ba == `BA_EXT3)
    ##2 (mrs && ba == `BA_EXT1 && !addr[0]) ##2 (mrs && ba == `BA_MAIN && addr[8]))
    else $error("register write order broken");
  chk_rst_pre_ref: assert property (mrs && ba == `BA_MAIN && addr[8] |-> ##2
    (cmd == `CMD_PRE && addr[10]) ##4 (cmd == `CMD_REF) ##32 (cmd == `CMD_REF))
    else $error("precharge and refreshes missing after loop reset");
  chk_mr_oper: assert property (mrs && ba == `BA_MAIN && !addr[8] |->
    !addr[7] && $past(cmd == `CMD_REF, 32)) else $error("operating main write wrong");
  chk_cal_lock: assert property (mrs && ba == `BA_EXT1 && addr[9:7] == 3'h7 |->
    since_rst_r >= DLL_LOCK_CYC - 1) else $error("calibration default too early");
  chk_cal_exit: assert property (mrs && ba == `BA_EXT1 && addr[9:7] == 3'h7 |-> ##2
    (mrs && ba == `BA_EXT1 && addr[9:7] == 3'h0)) else $error("calibration exit missing");
  chk_mrs_cke: assert property (mrs |-> cke && $past(cke))
    else $error("register write without clock enable");
  chk_ext2_zero: assert property (mrs && ba == `BA_EXT2 |-> (addr & ~`EXT2_OPER_MASK) == 13'h0000)
    else $error("reserved second extended bits set");
  chk_nop_gap: assert property (cmd != `CMD_NOP |=> cmd == `CMD_NOP)
    else $error("commands back to back");
endmodule : ddr2_init_sva

//--- ddr2_mem_end.sv
`include "ddr2_init_defs.svh"

module ddr2_mem_end #(
  parameter int unsigned DLL_LOCK_CYC = `DLL_LOCK_CLKS
) (
  // system
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // command bus
  ddr2_cmd_if.mem          bus,
  // decoded main register
  output logic [3:0]       burst_beats_o,
  output logic             burst_interleaved_o,
  output logic [2:0]       cas_latency_o,
  output logic             test_mode_o,
  output logic [3:0]       write_recovery_o,
  output logic             powerdown_exit_slow_o,
  // decoded first extended register
  output logic             dll_enabled_o,
  output logic             dll_locked_o,
  output logic             half_strength_o,
  output logic [2:0]       additive_latency_o,
  output logic [1:0]       termination_sel_o,
  output logic [2:0]       driver_calibration_o,
  output logic             strobe_n_disabled_o,
  // decoded second extended register
  output logic [2:0]       partial_array_refresh_o,
  output logic             high_temp_refresh_o,
  // state
  output logic             self_refresh_o,
  output logic [3:0]       regs_written_o
);

  function automatic logic [3:0] beats_of(input logic [2:0] code);
    beats_of = (code == `BURST_CODE_4) ? `BURST_BEATS_4 :
               (code == `BURST_CODE_8) ? `BURST_BEATS_8 : 4'h0;
  endfunction : beats_of

  logic        cke_prev_r;
  logic [12:0] regs_r [4];
  logic        self_ref_r;
  logic [7:0]  lock_cnt_r;
  logic        lock_run_r;

  ////////////////////////////////////////////////////////////////////////
  // command decode, sampled on the rising edge

  wire cmd_low   = ~bus.cs_n & ~bus.ras_n & ~bus.cas_n;
  wire reg_set   = cke_prev_r & bus.cke & cmd_low & ~bus.we_n;
  wire sr_entry  = cke_prev_r & ~bus.cke & cmd_low & bus.we_n;
  wire sr_exit   = ~cke_prev_r & bus.cke & self_ref_r;
  wire dll_reset = reg_set & (bus.ba == `BA_MAIN) & bus.addr[`MR_DLLRST_B];
  // relock also after self-refresh exit, since the loop restarts there
  wire lock_load = dll_reset | sr_exit;

  wire [12:0] mr   = regs_r[`BA_MAIN];
  wire [12:0] ext1 = regs_r[`BA_EXT1];
  wire [12:0] ext2 = regs_r[`BA_EXT2];
  wire [2:0]  cl_code = mr[`MR_CL_F];
  wire        cl_ok   = (cl_code >= `CL_MIN_CODE) && (cl_code <= `CL_MAX_CODE);
  wire        dll_on  = ~ext1[`EX1_DLL_DIS_B] & ~self_ref_r;

  ////////////////////////////////////////////////////////////////////////
  // register store

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cke_prev_r     <= 1'b0;
      regs_r         <= '{default: `ADDR_ZERO};
      regs_written_o <= 4'h0;
    end else begin
      cke_prev_r <= bus.cke;
      if (reg_set) begin
        regs_r[bus.ba]         <= bus.addr;
        regs_written_o[bus.ba] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      self_ref_r <= 1'b0;
    end else if (sr_entry) begin
      self_ref_r <= 1'b1;
    end else if (sr_exit) begin
      self_ref_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_cnt_r <= 8'h00;
      lock_run_r <= 1'b0;
    end else if (lock_load) begin
      lock_cnt_r <= 8'(DLL_LOCK_CYC - 1);
      lock_run_r <= 1'b1;
    end else if (lock_cnt_r != 8'h00) begin
      lock_cnt_r <= lock_cnt_r - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decoded outputs, one flop each

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      burst_beats_o           <= 4'h0;
      burst_interleaved_o     <= 1'b0;
      cas_latency_o           <= 3'h0;
      test_mode_o             <= 1'b0;
      write_recovery_o        <= 4'h0;
      powerdown_exit_slow_o   <= 1'b0;
      dll_enabled_o           <= 1'b0;
      dll_locked_o            <= 1'b0;
      half_strength_o         <= 1'b0;
      additive_latency_o      <= 3'h0;
      termination_sel_o       <= 2'h0;
      driver_calibration_o    <= 3'h0;
      strobe_n_disabled_o     <= 1'b0;
      partial_array_refresh_o <= 3'h0;
      high_temp_refresh_o     <= 1'b0;
      self_refresh_o          <= 1'b0;
    end else begin
      burst_beats_o           <= beats_of(mr[`MR_BURST_F]);
      burst_interleaved_o     <= mr[`MR_ORDER_B];
      cas_latency_o           <= cl_ok ? cl_code : 3'h0;
      test_mode_o             <= mr[`MR_TEST_B];
      // code 0 is reserved and reads as 0
      write_recovery_o        <= (mr[`MR_WR_F] == 3'h0) ? 4'h0 : {1'b0, mr[`MR_WR_F]} + 4'h1;
      powerdown_exit_slow_o   <= mr[`MR_PWRDN_B];
      dll_enabled_o           <= dll_on;
      dll_locked_o            <= dll_on & lock_run_r & (lock_cnt_r == 8'h00) & ~lock_load;
      half_strength_o         <= ext1[`EX1_HALF_B];
      additive_latency_o      <= ext1[`EX1_ADDLAT_F];
      termination_sel_o       <= {ext1[`EX1_RTT_HI_B], ext1[`EX1_RTT_LO_B]};
      driver_calibration_o    <= ext1[`EX1_CAL_F];
      strobe_n_disabled_o     <= ext1[`EX1_STROBE_N_B];
      partial_array_refresh_o <= ext2[`EX2_PAR_F];
      high_temp_refresh_o     <= ext2[`EX2_HOT_B];
      self_refresh_o          <= self_ref_r;
    end
  end

endmodule : ddr2_mem_end
